// ==== logic/thermal_overload_replica.sv ====
// thermal overload replica: rms per phase, first-order replica, thresholds
// assumes phase samples come from logic on ref_clk_in with a valid strobe
//
// Behaviour
// - true rms per phase over a window resolving harmonics up to tenth
// - the replica is fed each step with the largest phase rms
// - temperature rise is solved step by step, not in closed form
// - object temperature is rise plus the ambient setting
// - level follows first-order response toward squared current ratio
// - pulsed mode gives one trip pulse when crossing the trip setting
// - locked mode holds trip until temperature falls below unlock
// - alarm while temperature exceeds alarm setting, default 80 degrees
// - trip condition above trip setting, default 100 degrees
// - unlock setting, default 60, releases held trip and inhibit
// - ambient from manual setting, default 25 degrees
// - restart loads the replica from startup load setting, default 0 %
// - rated load current percent is the reference current, default 100
// - heating time constant in whole minutes, default 10
// - rated temperature setting, default 100, sets the level reference
// - base ambient setting, default 40, relates allowed temperature rise
// - three outputs: alarm, trip pulse, trip with restart inhibit
`timescale 1ns/10ps
`default_nettype none
module thermal_overload_replica
	import thermal_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int WIN_LOG2 = 5,
	parameter logic [15:0] NOM_RMS = 16'h2000,
	parameter logic [31:0] STEP_US = 32'h0000_4e20
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic sample_valid_in,
	input wire logic signed [SAMPLE_W-1:0] phase_a_in,
	input wire logic signed [SAMPLE_W-1:0] phase_b_in,
	input wire logic signed [SAMPLE_W-1:0] phase_c_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic alarm_out,
	output logic trip_pulse_out,
	output logic trip_lock_out,
	output logic irq_out
);
	localparam int SQ_W = 2 * SAMPLE_W;
	localparam int ACC_W = SQ_W + WIN_LOG2;
	localparam int TEMP_W = 41;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ALPHA = 3'b001,
		ST_WAIT_A = 3'b010,
		ST_QUOT = 3'b011,
		ST_WAIT_Q = 3'b100,
		ST_UPDATE = 3'b101
	} state_t;

	function automatic logic [SQ_W-1:0] square(
			input logic signed [SAMPLE_W-1:0] x);
		logic signed [SQ_W-1:0] p;
		p = x * x;
		return SQ_W'(unsigned'(p));
	endfunction

	function automatic logic [SQ_W-1:0] max3(input logic [SQ_W-1:0] a,
			input logic [SQ_W-1:0] b, input logic [SQ_W-1:0] c);
		logic [SQ_W-1:0] m;
		m = (a > b) ? a : b;
		return (c > m) ? c : m;
	endfunction

	function automatic logic [TEMP_W-1:0] deg_q(input logic [7:0] d);
		return {(TEMP_W - 8 - Q_FRAC)'(0), d, Q_FRAC'(0)};
	endfunction

	// settings and control
	mode_t mode;
	logic [7:0] alarm_t, trip_t, rated_t, base_t, unlock_t, ambient_t;
	logic [7:0] startup_pct, load_pct;
	logic [TCONST_W-1:0] tconst;
	logic [EV_W-1:0] status, mask, events;
	logic sw_restart, boot;
	logic wr_hit;

	// measurement and replica
	logic [WIN_LOG2-1:0] win_cnt;
	logic [ACC_W-1:0] acc [3];
	logic [SQ_W-1:0] ms [3];
	logic [SQ_W-1:0] sq_now [3];
	logic [SQ_W-1:0] ms_max;
	logic window_end;
	state_t state;
	logic [31:0] h, q_ratio, alpha;
	logic [31:0] next_h;
	logic div_start, div_done;
	logic [63:0] div_num, div_den, div_quo;
	logic [23:0] in_ref;
	logic [7:0] theta_n;
	logic [TEMP_W-1:0] temp_q;
	logic over_trip, over_trip_q;

	assign sq_now[0] = square(phase_a_in);
	assign sq_now[1] = square(phase_b_in);
	assign sq_now[2] = square(phase_c_in);
	assign wr_hit = reg_wr_in;

	// register writes
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode <= DEF_MODE;
			alarm_t <= DEF_ALARM_T;
			trip_t <= DEF_TRIP_T;
			rated_t <= DEF_RATED_T;
			base_t <= DEF_BASE_T;
			unlock_t <= DEF_UNLOCK_T;
			ambient_t <= DEF_AMBIENT_T;
			startup_pct <= DEF_STARTUP;
			load_pct <= DEF_LOAD_PCT;
			tconst <= DEF_TCONST;
			mask <= '0;
			sw_restart <= 1'b0;
		end else begin
			sw_restart <= 1'b0;
			if (wr_hit) begin
				case (reg_addr_in)
					REG_CTRL: begin
						mode <= mode_t'(reg_wdata_in[CTRL_MODE_LSB +: 2]);
						sw_restart <= reg_wdata_in[CTRL_RESTART_BIT];
					end
					REG_ALARM_T: alarm_t <= reg_wdata_in[7:0];
					REG_TRIP_T: trip_t <= reg_wdata_in[7:0];
					REG_RATED_T: rated_t <= reg_wdata_in[7:0];
					REG_BASE_T: base_t <= reg_wdata_in[7:0];
					REG_UNLOCK_T: unlock_t <= reg_wdata_in[7:0];
					REG_AMBIENT_T: ambient_t <= reg_wdata_in[7:0];
					REG_STARTUP: startup_pct <= reg_wdata_in[7:0];
					REG_LOAD_PCT: load_pct <= reg_wdata_in[7:0];
					REG_TCONST: tconst <= reg_wdata_in[TCONST_W-1:0];
					REG_MASK: mask <= reg_wdata_in[EV_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// sum of squares over one window; 32 samples a cycle reach past tenth
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			win_cnt <= '0;
			window_end <= 1'b0;
			ms_max <= '0;
			for (int i = 0; i < 3; i++) begin
				acc[i] <= '0;
				ms[i] <= '0;
			end
		end else begin
			window_end <= 1'b0;
			if (sample_valid_in) begin
				win_cnt <= win_cnt + WIN_LOG2'(1);
				for (int i = 0; i < 3; i++) begin
					if (&win_cnt) begin
						ms[i] <= SQ_W'((acc[i] + ACC_W'(sq_now[i])) >> WIN_LOG2);
						acc[i] <= '0;
					end else begin
						acc[i] <= acc[i] + ACC_W'(sq_now[i]);
					end
				end
				window_end <= &win_cnt;
			end
			// squares compare like rms values, so no root is needed
			if (state == ST_IDLE && window_end)
				ms_max <= max3(ms[0], ms[1], ms[2]);
		end
	end

	// divider jobs: step factor, then squared current ratio
	assign in_ref = 24'(NOM_RMS * load_pct);
	assign div_start = (state == ST_ALPHA) || (state == ST_QUOT);
	always_comb begin
		if (state == ST_ALPHA) begin
			div_num = 64'(STEP_US) << ALPHA_FRAC;
			div_den = US_PER_MIN * 64'((tconst == '0) ? 1 : tconst);
		end else begin
			div_num = (64'(ms_max) * PCT_SQ) << Q_FRAC;
			div_den = 64'(in_ref) * 64'(in_ref);
		end
	end

	serial_div #(.W(64)) u_div (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.start_in(div_start),
		.num_in(div_num),
		.den_in(div_den),
		.busy_out(),
		.done_out(div_done),
		.quo_out(div_quo)
	);

	// h moves toward q by alpha each step; alpha approximates 1-exp(-dt/T)
	always_comb begin
		logic signed [33:0] diff;
		logic signed [67:0] prod;
		logic signed [35:0] sum;
		diff = $signed({2'b00, q_ratio}) - $signed({2'b00, h});
		prod = diff * $signed({1'b0, alpha, 1'b0}) >>> 1;
		sum = $signed({4'h0, h}) + 36'(prod >>> ALPHA_FRAC);
		if (sum < 0)
			next_h = '0;
		else if (sum > $signed({4'h0, 32'hffff_ffff}))
			next_h = '1;
		else
			next_h = sum[31:0];
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= ST_IDLE;
			alpha <= '0;
			q_ratio <= '0;
		end else begin
			case (state)
				ST_IDLE: if (window_end) state <= ST_ALPHA;
				ST_ALPHA: state <= ST_WAIT_A;
				ST_WAIT_A: if (div_done) begin
					alpha <= div_quo[31:0];
					state <= ST_QUOT;
				end
				ST_QUOT: state <= ST_WAIT_Q;
				ST_WAIT_Q: if (div_done) begin
					q_ratio <= (|div_quo[63:32]) ? '1 : div_quo[31:0];
					state <= ST_UPDATE;
				end
				ST_UPDATE: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// replica level, loaded from the startup setting after any restart
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			boot <= 1'b1;
			h <= '0;
		end else begin
			boot <= 1'b0;
			if (boot || sw_restart)
				h <= (32'(startup_pct) << Q_FRAC) / PCT_FULL;
			else if (state == ST_UPDATE)
				h <= next_h;
		end
	end

	// object temperature; a rated not above base falls back to one degree
	assign theta_n = (rated_t > base_t) ? rated_t - base_t : 8'h01;
	assign temp_q = TEMP_W'(h * theta_n) + deg_q(ambient_t);
	assign over_trip = temp_q > deg_q(trip_t);

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			alarm_out <= 1'b0;
			trip_pulse_out <= 1'b0;
			trip_lock_out <= 1'b0;
			over_trip_q <= 1'b0;
		end else begin
			over_trip_q <= over_trip;
			alarm_out <= (mode != MODE_OFF) && (temp_q > deg_q(alarm_t));
			trip_pulse_out <= (mode == MODE_PULSED) && over_trip && !over_trip_q;
			if (mode != MODE_LOCKED)
				trip_lock_out <= 1'b0;
			else if (over_trip)
				trip_lock_out <= 1'b1;
			else if (temp_q < deg_q(unlock_t))
				trip_lock_out <= 1'b0;
		end
	end

	// sticky events; a new event beats a clear in the same cycle
	assign events[EV_ALARM] = (mode != MODE_OFF) && (temp_q > deg_q(alarm_t))
		&& !alarm_out;
	assign events[EV_TRIP] = (mode == MODE_PULSED) && over_trip && !over_trip_q
		|| (mode == MODE_LOCKED) && over_trip && !trip_lock_out;
	assign events[EV_RELEASE] = (mode == MODE_LOCKED) && trip_lock_out
		&& !over_trip && (temp_q < deg_q(unlock_t));

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			status <= '0;
		else if (wr_hit && reg_addr_in == REG_STATUS)
			status <= (status & ~reg_wdata_in[EV_W-1:0]) | events;
		else
			status <= status | events;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			irq_out <= 1'b0;
		else
			irq_out <= |((status | events) & mask);
	end

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= '0;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= '0;
		end else begin
			case (reg_addr_in)
				REG_CTRL: reg_rdata_out <= 32'(mode);
				REG_ALARM_T: reg_rdata_out <= 32'(alarm_t);
				REG_TRIP_T: reg_rdata_out <= 32'(trip_t);
				REG_RATED_T: reg_rdata_out <= 32'(rated_t);
				REG_BASE_T: reg_rdata_out <= 32'(base_t);
				REG_UNLOCK_T: reg_rdata_out <= 32'(unlock_t);
				REG_AMBIENT_T: reg_rdata_out <= 32'(ambient_t);
				REG_STARTUP: reg_rdata_out <= 32'(startup_pct);
				REG_LOAD_PCT: reg_rdata_out <= 32'(load_pct);
				REG_TCONST: reg_rdata_out <= 32'(tconst);
				REG_STATUS: reg_rdata_out <= 32'(status);
				REG_MASK: reg_rdata_out <= 32'(mask);
				REG_TEMP: reg_rdata_out <= temp_q[31:0];
				REG_LEVEL: reg_rdata_out <= h;
				REG_MSMAX: reg_rdata_out <= 32'(ms_max);
				REG_FLAGS: reg_rdata_out <= {29'h0, trip_lock_out,
					trip_pulse_out, alarm_out};
				default: reg_rdata_out <= '0;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);

	off_outputs_a: assert property ((mode == MODE_OFF) |=>
		(!alarm_out && !trip_pulse_out && !trip_lock_out))
		else $error("output active while mode is off");
	alarm_set_a: assert property ((mode != MODE_OFF && temp_q > deg_q(alarm_t))
		|=> alarm_out)
		else $error("alarm missing above alarm setting");
	pulse_single_a: assert property (trip_pulse_out |=> !trip_pulse_out)
		else $error("trip pulse longer than one cycle");
	pulse_cause_a: assert property (trip_pulse_out |->
		$past(over_trip) && !$past(over_trip_q))
		else $error("trip pulse without crossing");
	lock_hold_a: assert property ((trip_lock_out && mode == MODE_LOCKED
		&& temp_q >= deg_q(unlock_t)) |=> trip_lock_out)
		else $error("held trip released above unlock");
	lock_release_a: assert property ((trip_lock_out && mode == MODE_LOCKED
		&& !over_trip && temp_q < deg_q(unlock_t)) |=> !trip_lock_out)
		else $error("held trip not released below unlock");
	max_feed_a: assert property ($past(state == ST_IDLE && window_end) |->
		(ms_max >= ms[0] && ms_max >= ms[1] && ms_max >= ms[2]))
		else $error("replica not fed with largest phase");
	step_bound_a: assert property ((state == ST_ALPHA) |-> ##[130:140]
		(state == ST_UPDATE))
		else $error("replica step did not complete in time");
	heat_dir_a: assert property ((state == ST_UPDATE && q_ratio > h
		&& !sw_restart) |=> h >= $past(h))
		else $error("level fell while heating");
	restart_load_a: assert property (sw_restart |=>
		h == (32'($past(startup_pct)) << Q_FRAC) / PCT_FULL)
		else $error("restart did not load startup level");

	alarm_c: cover property (!alarm_out ##1 alarm_out);
	pulse_c: cover property (trip_pulse_out);
	lock_c: cover property (trip_lock_out ##[1:1000] !trip_lock_out);
	step_c: cover property (state == ST_UPDATE);
endmodule
`default_nettype wire

// ==== logic/thermal_pkg.sv ====
// constants shared by the thermal overload replica and its register port
// assumes word-indexed register port with 32-bit data
package thermal_pkg;

	// register indices (word addresses on the plain port)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ALARM_T = 4'h1;
	localparam logic [3:0] REG_TRIP_T = 4'h2;
	localparam logic [3:0] REG_RATED_T = 4'h3;
	localparam logic [3:0] REG_BASE_T = 4'h4;
	localparam logic [3:0] REG_UNLOCK_T = 4'h5;
	localparam logic [3:0] REG_AMBIENT_T = 4'h6;
	localparam logic [3:0] REG_STARTUP = 4'h7;
	localparam logic [3:0] REG_LOAD_PCT = 4'h8;
	localparam logic [3:0] REG_TCONST = 4'h9;
	localparam logic [3:0] REG_STATUS = 4'ha;
	localparam logic [3:0] REG_MASK = 4'hb;
	localparam logic [3:0] REG_TEMP = 4'hc;
	localparam logic [3:0] REG_LEVEL = 4'hd;
	localparam logic [3:0] REG_MSMAX = 4'he;
	localparam logic [3:0] REG_FLAGS = 4'hf;

	// control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_RESTART_BIT = 2;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_PULSED = 2'b01,
		MODE_LOCKED = 2'b10
	} mode_t;

	// setting defaults
	localparam mode_t DEF_MODE = MODE_PULSED;
	localparam logic [7:0] DEF_ALARM_T = 8'h50;
	localparam logic [7:0] DEF_TRIP_T = 8'h64;
	localparam logic [7:0] DEF_RATED_T = 8'h64;
	localparam logic [7:0] DEF_BASE_T = 8'h28;
	localparam logic [7:0] DEF_UNLOCK_T = 8'h3c;
	localparam logic [7:0] DEF_AMBIENT_T = 8'h19;
	localparam logic [7:0] DEF_STARTUP = 8'h00;
	localparam logic [7:0] DEF_LOAD_PCT = 8'h64;
	localparam logic [9:0] DEF_TCONST = 10'h00a;
	localparam int TCONST_W = 10;

	// status / mask bits
	localparam int EV_ALARM = 0;
	localparam int EV_TRIP = 1;
	localparam int EV_RELEASE = 2;
	localparam int EV_W = 3;

	// fixed point: thermal level and temperatures carry 16 fraction bits
	localparam int Q_FRAC = 16;
	localparam logic [31:0] PCT_FULL = 32'h0000_0064;
	localparam logic [63:0] PCT_SQ = 64'h0000_0000_0000_2710;
	localparam logic [63:0] US_PER_MIN = 64'h0000_0000_0393_8700;
	localparam int ALPHA_FRAC = 32;

endpackage

// ==== logic/serial_div.sv ====
// restoring serial divider, one quotient bit per clock
// assumes start only while not busy; den of zero gives all ones
`timescale 1ns/10ps
`default_nettype none
module serial_div #(
	parameter int W = 64
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic [W-1:0] num_in,
	input wire logic [W-1:0] den_in,
	output logic busy_out,
	output logic done_out,
	output logic [W-1:0] quo_out
);
	localparam int CW = $clog2(W + 1);

	logic [W-1:0] rem;
	logic [W-1:0] den;
	logic [CW-1:0] cnt;
	logic [W:0] shifted;
	logic [W+1:0] trial;

	assign shifted = {rem, quo_out[W-1]};
	assign trial = {1'b0, shifted} - {2'b00, den};

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rem <= '0;
			den <= '0;
			cnt <= '0;
			quo_out <= '0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_out) begin
				rem <= '0;
				den <= den_in;
				quo_out <= num_in;
				cnt <= CW'(W);
				busy_out <= 1'b1;
			end else if (busy_out) begin
				if (!trial[W+1]) begin
					rem <= trial[W-1:0];
					quo_out <= {quo_out[W-2:0], 1'b1};
				end else begin
					rem <= shifted[W-1:0];
					quo_out <= {quo_out[W-2:0], 1'b0};
				end
				cnt <= cnt - CW'(1);
				if (cnt == CW'(1)) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/phase_front_end.sv ====
// phase current front end model: three phases, windows of 32 samples
// assumes one clock shared with the design, one window sent at a time
`timescale 1ns/10ps
`default_nettype none
module phase_front_end #(
	parameter int GAP = 8
) (
	input wire logic clk_in,
	output logic valid_out,
	output logic signed [15:0] a_out,
	output logic signed [15:0] b_out,
	output logic signed [15:0] c_out
);
	initial begin
		valid_out = 1'b0;
		a_out = 16'h0000;
		b_out = 16'h0000;
		c_out = 16'h0000;
	end

	// every sample at full amplitude, so the mean square is exact
	task automatic send_window(input logic signed [15:0] a,
			input logic signed [15:0] b, input logic signed [15:0] c);
		for (int i = 0; i < 32; i++) begin
			repeat (GAP - 1) @(posedge clk_in);
			valid_out <= 1'b1;
			a_out <= i[1] ? -a : a;
			b_out <= i[1] ? -b : b;
			c_out <= i[2] ? -c : c;
			@(posedge clk_in);
			valid_out <= 1'b0;
			// lines between strobes show the inverse, not a stale sample
			a_out <= ~a_out;
			b_out <= ~b_out;
			c_out <= ~c_out;
		end
	endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the thermal overload replica
// assumes the package, the design and the front end model compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import thermal_pkg::*;
	// large step so the replica heats within a few windows
	localparam logic [31:0] STEP = 32'h0100_0000;
	logic ref_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [31:0] got;
	logic valid, alarm, pulse, lock, irq;
	logic signed [15:0] pa, pb, pc;
	int n_errors = 0;
	int n_checks = 0;
	int seed = 22;
	int n_pulse = 0;
	int p0;
	int def_v [12] = '{1, 80, 100, 100, 40, 60, 25, 0, 100, 10, 0, 0};
	longint h_m, ms, tgt;
	logic [31:0] d;
	logic signed [15:0] ra, rb, rc;

	initial begin
		forever #50 ref_clk_in = ~ref_clk_in;
	end

	phase_front_end fe_u (
		.clk_in(ref_clk_in),
		.valid_out(valid),
		.a_out(pa),
		.b_out(pb),
		.c_out(pc)
	);

	thermal_overload_replica #(.STEP_US(STEP)) dut_u (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.sample_valid_in(valid),
		.phase_a_in(pa),
		.phase_b_in(pb),
		.phase_c_in(pc),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.alarm_out(alarm),
		.trip_pulse_out(pulse),
		.trip_lock_out(lock),
		.irq_out(irq)
	);

	always @(posedge ref_clk_in) begin
		if (pulse === 1'b1) n_pulse <= n_pulse + 1;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// fixed-point rounding of the replica differs slightly from the model
	task automatic chk_near(input logic [31:0] g, input longint e,
			input longint tol);
		longint df;
		df = longint'(g) - e;
		n_checks++;
		if ($isunknown(g) || df > tol || df < -tol) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e[31:0]);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge ref_clk_in);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge ref_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_in);
		rd <= 1'b0;
		@(negedge ref_clk_in);
		v = rdata;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
	endtask

	task automatic outs(input logic a, input logic l, input logic i);
		chk({29'h0, alarm, lock, irq}, {29'h0, a, l, i});
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk_in);
		n_errors++;
		wrap_up;
	end

	initial begin
		repeat (16) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			rd_reg(i[3:0], got);
			chk(got, def_v[i]);
		end
		rd_reg(REG_TEMP, got);
		chk(got, 32'h0019_0000);
		for (int i = 1; i < 10; i++) begin
			d = $random(seed) & (i == 9 ? 32'h3ff : 32'hff);
			wr_reg(i[3:0], d);
			rd_reg(i[3:0], got);
			chk(got, d);
			wr_reg(i[3:0], def_v[i]);
		end
		wr_reg(REG_LEVEL, 32'h1234);
		rd_reg(REG_LEVEL, got);
		chk(got, 32'h0);
		$display("test settings done");

		wr_reg(REG_STARTUP, 32'd50);
		wr_reg(REG_AMBIENT_T, 32'd30);
		wr_reg(REG_CTRL, 32'h5);
		tick(3);
		rd_reg(REG_LEVEL, got);
		chk(got, 32'h0000_8000);
		rd_reg(REG_TEMP, got);
		chk(got, 32'h003c_0000);
		$display("test restart done");

		wr_reg(REG_STATUS, 32'h7);
		wr_reg(REG_MASK, 32'h1);
		wr_reg(REG_ALARM_T, 32'd60);
		tick(3);
		outs(1'b0, 1'b0, 1'b0);
		wr_reg(REG_ALARM_T, 32'd59);
		tick(3);
		outs(1'b1, 1'b0, 1'b1);
		rd_reg(REG_STATUS, got);
		chk(got, 32'h1);
		wr_reg(REG_MASK, 32'h0);
		tick(2);
		outs(1'b1, 1'b0, 1'b0);
		wr_reg(REG_MASK, 32'h1);
		wr_reg(REG_STATUS, 32'h1);
		tick(2);
		outs(1'b1, 1'b0, 1'b0);
		$display("test alarm done");

		p0 = n_pulse;
		wr_reg(REG_TRIP_T, 32'd60);
		tick(5);
		chk(n_pulse - p0, 0);
		wr_reg(REG_TRIP_T, 32'd59);
		tick(20);
		chk(n_pulse - p0, 1);
		$display("test pulse done");

		wr_reg(REG_CTRL, 32'h2);
		tick(3);
		outs(1'b1, 1'b1, 1'b0);
		wr_reg(REG_TRIP_T, 32'd70);
		wr_reg(REG_UNLOCK_T, 32'd60);
		tick(3);
		outs(1'b1, 1'b1, 1'b0);
		wr_reg(REG_UNLOCK_T, 32'd61);
		tick(3);
		outs(1'b1, 1'b0, 1'b0);
		rd_reg(REG_STATUS, got);
		chk({31'h0, got[EV_RELEASE]}, 32'h1);
		chk(n_pulse - p0, 1);
		$display("test lock done");

		wr_reg(REG_CTRL, 32'h0);
		wr_reg(REG_TRIP_T, 32'd59);
		wr_reg(REG_UNLOCK_T, 32'd20);
		tick(5);
		outs(1'b0, 1'b0, 1'b0);
		chk(n_pulse - p0, 1);
		$display("test off done");

		wr_reg(REG_ALARM_T, 32'd80);
		wr_reg(REG_TRIP_T, 32'd100);
		wr_reg(REG_UNLOCK_T, 32'd60);
		wr_reg(REG_AMBIENT_T, 32'd25);
		wr_reg(REG_STARTUP, 32'd0);
		wr_reg(REG_TCONST, 32'd1);
		wr_reg(REG_LOAD_PCT, 32'd110);
		wr_reg(REG_CTRL, 32'h5);
		p0 = n_pulse;
		h_m = 0;
		for (int w = 0; w < 5; w++) begin
			ra = 16'sd12288 + 16'($random(seed) & 32'hfff);
			rb = 16'sd12288 + 16'($random(seed) & 32'hfff);
			rc = 16'sd12288 + 16'($random(seed) & 32'hfff);
			fe_u.send_window(ra, rb, rc);
			ms = ra > rb ? ra : rb;
			ms = rc > ms ? rc : ms;
			ms = ms * ms;
			tgt = ms * 10000 * 65536 / ((64'd8192 * 110) ** 2);
			h_m = h_m + (tgt - h_m) * longint'(STEP) / 60000000;
			tick(300);
			rd_reg(REG_MSMAX, got);
			chk(got, ms[31:0]);
			rd_reg(REG_LEVEL, got);
			chk_near(got, h_m, 64);
			rd_reg(REG_TEMP, got);
			chk_near(got, h_m * 60 + 25 * 65536, 4096);
			chk({31'h0, alarm}, {31'h0, got > 32'h0050_0000});
		end
		chk(n_pulse - p0, 1);
		$display("test heating done");
		wrap_up;
	end
endmodule
`default_nettype wire
